// ### dfs_disk_model.sv
// Purpose: Disk unit and read channel model for the status and compare block
// Assumes: Addresses pass only while a unit is selected and the block is busy
// Notes:   i_bad spoils one home identifier character so the search fails except in MODE_SRO, which ignores a home mismatch
module dfs_disk_model
  import dfs_pkg::*;
(
  // Clock, reset and search control
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_busy,
  input  wire logic [SEL_W-1:0]  i_sel,
  input  wire logic [ADDR_W-1:0] i_target,
  input  wire logic              i_bad,
  // Read channel lines
  output logic                   o_index,
  output logic                   o_rec_valid,
  output logic                   o_rec_is_home,
  output logic [ADDR_W-1:0]      o_rec_addr,
  output logic                   o_ccg_ok
);
  logic [7:0] tick_r;
  // Index each 256 cycles, home address then record address in between
  always_ff @(posedge i_clk) begin
    tick_r        <= (i_busy && i_sel != '0) ? tick_r + 8'h01 : 8'h00;
    o_index       <= (tick_r == 8'hff);
    o_rec_valid   <= (tick_r == 8'h40) || (tick_r == 8'h80);
    o_rec_is_home <= (tick_r == 8'h40);
    o_ccg_ok      <= 1'b1; // Code generator healthy
    if (i_rst) begin
      o_rec_addr <= '0;
    end else if (tick_r == 8'h40) begin
      o_rec_addr <= i_target ^ (i_bad ? 48'h0010_0000_0000 : 48'h0); // Home exact
    end else if (tick_r == 8'h80) begin
      o_rec_addr <= i_target ^ 48'h000c_30c3_0000; // Track zones arbitrary
    end else begin
      o_rec_addr <= ~o_rec_addr; // Stale value never lingers
    end
  end
endmodule

// ### dfs_pkg.sv
// Purpose: Shared constants and types of the disk file status and address compare block
// Assumes: 200 MHz control clock, Avalon-MM register slave with byte addresses
// Notes:   Every offset, field position and timing count lives here; registers reset to zero in the block
package dfs_pkg;
  // Register byte offsets
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR0  = 5'h04;
  localparam logic [4:0] REG_ADDR1  = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_COUNT  = 5'h10;
  localparam logic [4:0] REG_STATE  = 5'h14;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PAR    = 3;
  localparam int CMD_MODE   = 4;
  localparam int CMD_EIGHT  = 6;
  // Operation codes
  localparam logic [2:0] OP_SEEK_TEST = 3'h1;
  localparam logic [2:0] OP_READ      = 3'h2;
  localparam logic [2:0] OP_WRITE     = 3'h3;
  localparam logic [2:0] OP_WCHK      = 3'h4;
  localparam logic [2:0] OP_FORMAT    = 3'h5;
  localparam logic [2:0] OP_HA_READ   = 3'h6;
  localparam logic [2:0] OP_HA_WRITE  = 3'h7;
  // Operating modes
  localparam logic [1:0] MODE_SRO = 2'h0;
  localparam logic [1:0] MODE_TRO = 2'h1;
  localparam logic [1:0] MODE_TWA = 2'h2;
  localparam logic [1:0] MODE_CYO = 2'h3;
  // Status bit positions
  localparam int ST_DATA_CHECK = 0;
  localparam int ST_INV_ADDR   = 1;
  localparam int ST_BUSY       = 2;
  localparam int ST_NOT_READY  = 3;
  localparam int ST_ACC_INOP   = 4;
  localparam int ST_HAO_CHK    = 5;
  localparam int ST_EXT        = 6;
  localparam int ST_WRONG_LEN  = 7;
  localparam int ST_NO_REC     = 8;
  localparam int ST_WCHK_NOMOD = 9;
  localparam int ST_FRAME_CHK  = 10;
  localparam int ST_CTRL_CHK   = 11;
  localparam int ST_INV_OP     = 12;
  localparam int STAT_W        = 13;
  localparam logic [STAT_W-1:0] EXT_MASK = 13'h1f80;
  // Synchronised pin positions
  localparam int SY_MOTION = 0;
  localparam int SY_OPER   = 1;
  localparam int SY_FREADY = 2;
  localparam int SY_WDFAIL = 3;
  localparam int SY_SVC    = 4;
  localparam int SY_HAO    = 5;
  localparam int SY_GAP_OK = 6;
  localparam int SY_W      = 7;
  // Address layout: eight six-bit characters, access digit first
  localparam int DIG_W   = 6;
  localparam int ADDR_W  = 48;
  localparam int ACC_NUM = 2;
  localparam int MOD_NUM = 5;
  localparam int SEL_W   = 10;
  localparam logic [ADDR_W-1:0] CMP_TEST_PAT = 48'h5a5_a5a_c3c_3c3;
  localparam logic [ADDR_W-1:0] CMP_FLIP     = 48'h0400_0000_0000;
  // Timing
  localparam int CLK_NS          = 5;
  localparam int T_ADDR_XFER_NS  = 160000;
  localparam int T_STRB6_NS      = 11100;
  localparam int T_STRB8_NS      = 14200;
  localparam int T_MIN_MOVE_NS   = 10700;
  localparam int T_MIN_LOAD_NS   = 13800;
  localparam int ADDR_XFER_CYC   = (T_ADDR_XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] STRB6_CYC   = 16'((T_STRB6_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] STRB8_CYC   = 16'((T_STRB8_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] MIN_MOVE_CYC = 16'((T_MIN_MOVE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] MIN_LOAD_CYC = 16'((T_MIN_LOAD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  FILLER_MIN  = 8'h04;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_XFER, S_SELECT, S_CMP_TEST, S_SEARCH, S_CCG_TEST, S_DATA, S_FMT_TAIL, S_DONE
  } dfs_st_t;
endpackage

// ### dfs_status_cmp.sv
// Purpose: Status conditions, self-checks, access decode and address compare of a disk control
// Assumes: Mechanical disk lines are asynchronous; recorded addresses, index, filler,
//          disconnect and cyclic-code check come from logic on i_clk
// Notes:   Avalon-MM slave answers every access on the second edge after the request
module dfs_status_cmp
  import dfs_pkg::*;
#(
  parameter logic [15:0] XFER_CYC = 16'(ADDR_XFER_CYC)
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [4:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Asynchronous disk unit and panel lines
  input  wire logic              i_acc_motion,
  input  wire logic              i_acc_operative,
  input  wire logic              i_file_ready,
  input  wire logic              i_write_drv_fail,
  input  wire logic              i_service_track,
  input  wire logic              i_home_address_op_switch,
  input  wire logic              i_gap_tol_ok,
  // Read channel and data path, same clock
  input  wire logic              i_index,
  input  wire logic              i_rec_valid,
  input  wire logic              i_rec_is_home,
  input  wire logic [ADDR_W-1:0] i_rec_addr,
  input  wire logic              i_ccg_ok,
  input  wire logic              i_disconnect,
  input  wire logic              i_filler,
  // Host channel and access selection
  output logic                   o_ready,
  output logic                   o_chan_busy,
  output logic                   o_addr_xfer,
  output logic                   o_data_strobe,
  output logic                   o_end_op,
  output logic [SEL_W-1:0]       o_acc_sel
);

  typedef struct packed {
    dfs_st_t           st;
    logic [7:0]        cmd;
    logic [23:0]       a0;
    logic [23:0]       a1;
    logic [15:0]       cnt;
    logic [15:0]       tmr;
    logic [1:0]        idx;
    logic [7:0]        fill;
    logic              mode_ok;
    logic [STAT_W-1:0] stat;
    logic [SY_W-1:0]   s1;
    logic [SY_W-1:0]   s2;
    logic [SY_W-1:0]   s3;
    logic [SY_W-1:0]   f;
    logic              ack;
    logic [31:0]       rdata;
    logic              strobe;
    logic              endop;
    logic              rdy;
    logic [SEL_W-1:0]  sel;
  } dfs_state_t;

  dfs_state_t        q_r;
  dfs_state_t        q_nxt;
  logic [STAT_W-1:0] set_v;
  logic [STAT_W-1:0] clr_v;
  logic              wr_take;
  logic              cmd_wr;
  logic              busy_now;
  logic [2:0]        op;
  logic [1:0]        mode;
  logic              rw_op;
  logic [ADDR_W-1:0] tgt;
  logic [15:0]       strb_cyc;

  // Address compare: access and module digits skipped, track numeric only
  function automatic logic addr_match(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    logic ok;
    ok = 1'b1;
    for (int d = 2; d < 8; d++) begin
      if (d < 6) begin
        ok = ok & (a[d*DIG_W +: 4] == b[d*DIG_W +: 4]);
      end else begin
        ok = ok & (a[d*DIG_W +: DIG_W] == b[d*DIG_W +: DIG_W]);
      end
    end
    return ok;
  endfunction

  // Read mux for the register slave
  function automatic logic [31:0] reg_read(input dfs_state_t s, input logic [4:0] adr);
    logic [31:0] v;
    v = 32'h0;
    case ({adr[4:2], 2'b00})
      REG_CMD:    v = {24'h0, s.cmd};
      REG_ADDR0:  v = {8'h0, s.a0};
      REG_ADDR1:  v = {8'h0, s.a1};
      REG_STATUS: v = {{(32 - STAT_W){1'b0}}, s.stat};
      REG_COUNT:  v = {16'h0, s.cnt};
      REG_STATE:  v = {20'h0, s.mode_ok, s.f, s.st};
      default:    v = 32'h0;
    endcase
    return v;
  endfunction

  // Decoded fields of the held command and target address
  always_comb begin
    op       = q_r.cmd[CMD_OP_LSB +: 3];
    mode     = q_r.cmd[CMD_MODE +: 2];
    rw_op    = (op == OP_READ) || (op == OP_WRITE) || (op == OP_WCHK) || (op == OP_FORMAT);
    tgt      = {q_r.a1, q_r.a0};
    strb_cyc = q_r.cmd[CMD_EIGHT] ? STRB8_CYC : STRB6_CYC;
    wr_take  = i_avs_write & q_r.ack;
    cmd_wr   = wr_take && ({i_avs_address[4:2], 2'b00} == REG_CMD);
    busy_now = (q_r.st != S_IDLE) | q_r.f[SY_MOTION];
    clr_v    = '0;
    if (wr_take && ({i_avs_address[4:2], 2'b00} == REG_STATUS)) begin
      clr_v = i_avs_writedata[STAT_W-1:0];
    end
  end

  // Next-state logic for every register of the block
  always_comb begin
    logic [2:0] nop;
    logic       par_ok;
    logic [3:0] dig_a;
    logic [3:0] dig_m;
    nop    = i_avs_writedata[CMD_OP_LSB +: 3];
    par_ok = ^i_avs_writedata[CMD_PAR:0];
    dig_a  = q_r.a0[3:0];
    dig_m  = q_r.a0[DIG_W +: 4];
    q_nxt  = q_r;
    set_v  = '0;
    q_nxt.strobe = 1'b0;
    q_nxt.endop  = 1'b0;
    // Three-stage pin synchroniser; a change counts when stages two and three agree
    q_nxt.s1 = {i_gap_tol_ok, i_home_address_op_switch, i_service_track, i_write_drv_fail,
                i_file_ready, i_acc_operative, i_acc_motion};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.f  = (q_r.s2 & q_r.s3) | (q_r.f & (q_r.s2 | q_r.s3));
    // Bus slave: acknowledge one cycle after the request, read data caught early
    q_nxt.ack = (i_avs_read | i_avs_write) & ~q_r.ack;
    if (i_avs_read && !q_r.ack) begin
      q_nxt.rdata = reg_read(q_r, i_avs_address);
    end
    if (wr_take && ({i_avs_address[4:2], 2'b00} == REG_ADDR0) && !busy_now) begin
      q_nxt.a0 = i_avs_writedata[23:0];
    end
    if (wr_take && ({i_avs_address[4:2], 2'b00} == REG_ADDR1) && !busy_now) begin
      q_nxt.a1 = i_avs_writedata[23:0];
    end
    if (wr_take && ({i_avs_address[4:2], 2'b00} == REG_COUNT) && !busy_now) begin
      q_nxt.cnt = i_avs_writedata[15:0];
    end
    // Ready is driven high only while the addressed unit is alive
    q_nxt.rdy = q_r.f[SY_OPER] & q_r.f[SY_FREADY] & ~q_r.stat[ST_NOT_READY];
    // Command acceptance and checks made before anything moves
    if (cmd_wr) begin
      if (busy_now) begin
        set_v[ST_BUSY] = 1'b1;
      end else if (!par_ok || nop == 3'h0) begin
        set_v[ST_INV_OP] = 1'b1;
        q_nxt.endop      = 1'b1;
      end else if ((nop == OP_HA_READ || nop == OP_HA_WRITE) && !q_r.f[SY_HAO]) begin
        set_v[ST_HAO_CHK]   = 1'b1;
        set_v[ST_NOT_READY] = 1'b1;
        q_nxt.endop         = 1'b1;
      end else if (nop == OP_WCHK && !q_r.mode_ok) begin
        set_v[ST_WCHK_NOMOD] = 1'b1;
        q_nxt.endop          = 1'b1;
      end else begin
        q_nxt.cmd = i_avs_writedata[7:0];
        q_nxt.st  = S_XFER;
        q_nxt.tmr = XFER_CYC - 16'h1;
        if (nop != OP_WCHK) begin
          q_nxt.mode_ok = 1'b0;
        end
      end
    end
    case (q_r.st)
      S_IDLE: begin
        q_nxt.sel = q_nxt.sel;
      end
      S_XFER: begin
        q_nxt.tmr = q_r.tmr - 16'h1;
        if (q_r.tmr == 16'h0) begin
          q_nxt.st = S_SELECT;
        end
      end
      S_SELECT: begin
        q_nxt.sel = '0;
        if (dig_a >= 4'(ACC_NUM) || dig_m >= 4'(MOD_NUM)) begin
          set_v[ST_ACC_INOP]  = 1'b1;
          set_v[ST_NOT_READY] = 1'b1;
          q_nxt.st            = S_DONE;
        end else begin
          q_nxt.sel[4'(dig_a * 4'(MOD_NUM)) + dig_m] = 1'b1;
          if (!q_r.f[SY_OPER]) begin
            set_v[ST_ACC_INOP]  = 1'b1;
            set_v[ST_NOT_READY] = 1'b1;
            q_nxt.st            = S_DONE;
          end else if (q_r.f[SY_MOTION]) begin
            q_nxt.st = S_SELECT;
          end else if (op == OP_SEEK_TEST) begin
            q_nxt.mode_ok = 1'b1;
            q_nxt.st      = S_DONE;
          end else if (rw_op && q_r.f[SY_SVC]) begin
            set_v[ST_INV_ADDR]   = 1'b1;
            set_v[ST_DATA_CHECK] = 1'b1;
            q_nxt.st             = S_DONE;
          end else begin
            q_nxt.st = S_CMP_TEST;
          end
        end
      end
      S_CMP_TEST: begin
        q_nxt.idx = 2'h0;
        if (addr_match(CMP_TEST_PAT, CMP_TEST_PAT) &&
            !addr_match(CMP_TEST_PAT, CMP_TEST_PAT ^ CMP_FLIP)) begin
          q_nxt.st = S_SEARCH;
        end else begin
          set_v[ST_CTRL_CHK] = 1'b1;
        end
      end
      S_SEARCH: begin
        if (i_index) begin
          q_nxt.idx = q_r.idx + 2'h1;
          if (mode == MODE_SRO && q_r.idx == 2'h1) begin
            set_v[ST_NO_REC] = 1'b1;
          end
        end
        if (i_rec_valid) begin
          if (addr_match(i_rec_addr, tgt)) begin
            q_nxt.tmr  = strb_cyc - 16'h1;
            q_nxt.fill = 8'h0;
            q_nxt.st   = (op == OP_WRITE || op == OP_FORMAT || op == OP_HA_WRITE) ?
                         S_CCG_TEST : S_DATA;
          end else if (i_rec_is_home && mode != MODE_SRO) begin
            set_v[ST_NO_REC] = 1'b1;
          end
        end
      end
      S_CCG_TEST: begin
        if (i_ccg_ok) begin
          q_nxt.st = S_DATA;
        end else begin
          set_v[ST_CTRL_CHK] = 1'b1;
        end
      end
      S_DATA: begin
        q_nxt.tmr = q_r.tmr - 16'h1;
        if (q_r.tmr == 16'h0) begin
          q_nxt.strobe = 1'b1;
          q_nxt.tmr    = strb_cyc - 16'h1;
          q_nxt.cnt    = q_r.cnt - 16'h1;
        end
        if (op == OP_WCHK && mode == MODE_TWA && !q_r.f[SY_GAP_OK]) begin
          set_v[ST_CTRL_CHK] = 1'b1;
        end
        if (i_disconnect || (q_r.tmr == 16'h0 && q_r.cnt == 16'h1)) begin
          q_nxt.st = (op == OP_FORMAT) ? S_FMT_TAIL : S_DONE;
          if (op == OP_READ || op == OP_WRITE) begin
            q_nxt.mode_ok = 1'b1;
          end
        end
      end
      S_FMT_TAIL: begin
        if (i_filler && q_r.fill != 8'hff) begin
          q_nxt.fill = q_r.fill + 8'h1;
        end
        if (i_index) begin
          q_nxt.st = S_DONE;
          if (q_r.fill < FILLER_MIN) begin
            set_v[ST_WRONG_LEN] = 1'b1;
          end
        end
      end
      S_DONE: begin
        q_nxt.endop = 1'b1;
        q_nxt.st    = S_IDLE;
      end
      default: begin
        q_nxt.st = S_IDLE;
      end
    endcase
    // Lost unit lines or a failing write driver while the unit is in use
    if (q_r.st > S_SELECT && q_r.st != S_DONE &&
        (q_r.f[SY_WDFAIL] || !q_r.f[SY_OPER] || !q_r.f[SY_FREADY])) begin
      set_v[ST_FRAME_CHK] = 1'b1;
    end
    set_v[ST_EXT] = |(set_v & EXT_MASK);
    // Serious conditions abandon the operation at once
    if ((|(set_v & EXT_MASK)) && q_r.st != S_IDLE && q_r.st != S_DONE) begin
      q_nxt.st = S_DONE;
      if (op == OP_WCHK || op == OP_SEEK_TEST) begin
        q_nxt.mode_ok = 1'b0;
      end
    end
    // Sticky status: a new event wins over a clear in the same cycle
    q_nxt.stat = (q_r.stat & ~clr_v) | set_v;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs
  assign o_avs_readdata    = q_r.rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~q_r.ack;
  assign o_ready           = q_r.rdy;
  assign o_chan_busy       = (q_r.st != S_IDLE);
  assign o_addr_xfer       = (q_r.st == S_XFER);
  assign o_data_strobe     = q_r.strobe;
  assign o_end_op          = q_r.endop;
  assign o_acc_sel         = q_r.sel;

  // Helper counters for the timing checks
  logic [15:0] xfer_cnt_r;
  logic [15:0] gap_cnt_r;
  logic        seen_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      xfer_cnt_r <= 16'h0;
      gap_cnt_r  <= 16'h0;
      seen_r     <= 1'b0;
    end else begin
      xfer_cnt_r <= (q_r.st == S_XFER) ? xfer_cnt_r + 16'h1 : 16'h0;
      gap_cnt_r  <= o_data_strobe ? 16'h1 : (gap_cnt_r == 16'hffff ? gap_cnt_r : gap_cnt_r + 16'h1);
      seen_r     <= o_data_strobe ? 1'b1 : (q_r.st == S_IDLE ? 1'b0 : seen_r);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence ext_stop_s;
    (q_r.st == S_DONE) ##1 o_end_op;
  endsequence

  a_busy_refuse: assert property (cmd_wr && busy_now |=> q_r.stat[ST_BUSY])
    else $error("command accepted while busy");
  a_motion_hold: assert property ((q_r.st == S_SELECT) && q_r.f[SY_MOTION] && q_r.f[SY_OPER]
    && (tgt[3:0] < 4'(ACC_NUM)) && (tgt[9:6] < 4'(MOD_NUM)) |=> (q_r.st == S_SELECT))
    else $error("operation moved on with actuator in motion");
  a_chan_busy: assert property (o_chan_busy && (q_r.st != S_DONE) |=> o_chan_busy)
    else $error("channel busy dropped before release");
  a_ready_lost: assert property (!q_r.f[SY_OPER] |=> !o_ready)
    else $error("ready shown without operative unit");
  a_bad_opcode: assert property (cmd_wr && !busy_now && !(^i_avs_writedata[3:0])
    |=> q_r.stat[ST_INV_OP] && q_r.stat[ST_EXT] && o_end_op && !o_chan_busy)
    else $error("bad parity op code not flagged");
  a_ext_stop: assert property ((|(set_v & EXT_MASK)) && (q_r.st inside {[S_XFER:S_FMT_TAIL]})
    |=> ext_stop_s)
    else $error("external condition did not stop at once");
  a_strobe_gap: assert property (o_data_strobe && seen_r |-> gap_cnt_r >= MIN_MOVE_CYC)
    else $error("data strobes closer than least spacing");
  a_xfer_time: assert property ($fell(q_r.st == S_XFER) |-> xfer_cnt_r == XFER_CYC)
    else $error("address transfer length wrong");
  a_svc_track: assert property ((q_r.st == S_SELECT) && q_r.f[SY_OPER] && !q_r.f[SY_MOTION]
    && rw_op && q_r.f[SY_SVC] && (q_r.sel != '0 || 1'b1) && (tgt[3:0] < 4'(ACC_NUM))
    && (tgt[9:6] < 4'(MOD_NUM)) |=> q_r.stat[ST_INV_ADDR] && q_r.stat[ST_DATA_CHECK])
    else $error("service track access not flagged");
  a_cmp_selftest: assert property ($rose(q_r.st == S_SEARCH) |-> $past(q_r.st) == S_CMP_TEST)
    else $error("compare began without comparator self-test");

endmodule

// ### testbench.sv
// Purpose: Self-checking bench of the disk status and address compare block
// Assumes: Short address transfer parameter; disk model answers searches
// Notes:   Status reads are noted in a queue and judged by the read monitor
module testbench
  import dfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] XFER_T = 16'h0014;
  logic              i_clk, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [4:0]        i_avs_address;
  logic [31:0]       i_avs_writedata, o_avs_readdata;
  logic              motion, oper, svc, home_address_op_switch, bad, idx, rvalid, rhome, ccg_ok, timing_on;
  logic              fil, wdf, gok, frdy, eight;
  logic              o_ready, o_chan_busy, o_addr_xfer, o_data_strobe, o_end_op;
  logic [ADDR_W-1:0] raddr, target, spoil;
  logic [SEL_W-1:0]  o_acc_sel;
  logic [5:0]        m;
  logic [63:0]       notes[$];
  int                errors, checks_done, xfer_n, gap;
  dfs_status_cmp #(.XFER_CYC(XFER_T)) dfs_status_cmp_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_acc_motion(motion), .i_acc_operative(oper),
    .i_file_ready(frdy), .i_write_drv_fail(wdf), .i_service_track(svc),
    .i_home_address_op_switch(home_address_op_switch), .i_gap_tol_ok(gok), .i_index(idx), .i_rec_valid(rvalid),
    .i_rec_is_home(rhome), .i_rec_addr(raddr), .i_ccg_ok(ccg_ok), .i_disconnect(1'b0),
    .i_filler(fil), .o_ready(o_ready), .o_chan_busy(o_chan_busy), .o_addr_xfer(o_addr_xfer),
    .o_data_strobe(o_data_strobe), .o_end_op(o_end_op), .o_acc_sel(o_acc_sel));
  dfs_disk_model dfs_disk_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_busy(o_chan_busy),
    .i_sel(o_acc_sel), .i_target(target ^ spoil), .i_bad(bad), .o_index(idx), .o_rec_valid(rvalid),
    .o_rec_is_home(rhome), .o_rec_addr(raddr), .o_ccg_ok(ccg_ok));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_read      <= rd;
    i_avs_write     <= !rd;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) errors++;
    if (n >= 100) close_out();
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  function automatic logic [6:0] mk(input logic [2:0] op, input logic [1:0] mode);
    return {1'b0, mode, ~^op, op};
  endfunction
  // Clear status, load address and count, start, await end, note status
  task automatic run_op(input logic [6:0] cmd, input logic retry, input logic [31:0] exp,
                        input logic [31:0] mask);
    int n;
    bus(1'b0, REG_STATUS, 32'h1fff);
    bus(1'b0, REG_ADDR0, {8'h0, target[23:0]});
    bus(1'b0, REG_ADDR1, {8'h0, target[47:24]});
    bus(1'b0, REG_COUNT, 32'h2);
    gap = 0;
    bus(1'b0, REG_CMD, {25'h0, cmd});
    if (retry) begin
      bus(1'b0, REG_CMD, {25'h0, cmd});
      chk(32'(o_chan_busy), 32'h1);
    end
    n = 0;
    while (o_end_op !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000) errors++;
    if (n >= 20000) close_out();
    notes.push_back({mask, exp});
    bus(1'b1, REG_STATUS, 32'h0);
  endtask
  // Read monitor and transfer timing watch
  always @(posedge i_clk) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && notes.size() > 0) begin
      chk(o_avs_readdata & notes[0][63:32], notes[0][31:0]);
      void'(notes.pop_front());
    end
    if (o_addr_xfer === 1'b1) xfer_n++;
    else if (xfer_n > 0 && timing_on) chk(32'(xfer_n), 32'(XFER_T));
    if (o_addr_xfer !== 1'b1) xfer_n = 0;
    if (o_data_strobe === 1'b1 && gap > 0 && timing_on)
      chk(32'(gap), eight ? 32'(STRB8_CYC) : 32'(STRB6_CYC));
    if (o_data_strobe === 1'b1) gap = 1;
    else if (gap > 0) gap++;
  end
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, motion, svc, home_address_op_switch, bad} = '0;
    {fil, wdf, eight, spoil} = '0;
    {i_rst, oper, timing_on, gok, frdy} = 5'b11011;
    void'($urandom(51452));
    m = 6'($urandom % 5);
    target = 48'({$urandom, $urandom} & 64'hffff_ffff_f000) | {36'h0, m, 6'h00};
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    run_op(mk(3'h0, MODE_TRO), 1'b0, 32'h1000, 32'h1000);
    run_op(mk(OP_READ, MODE_TRO) ^ 7'h08, 1'b0, 32'h1000, 32'h1000);
    run_op(mk(OP_WCHK, MODE_TRO), 1'b0, 32'h0200, 32'h0200);
    run_op(mk(OP_HA_READ, MODE_TRO), 1'b0, 32'h0028, 32'h0028);
    svc <= 1'b1;
    run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0003, 32'h0003);
    svc <= 1'b0;
    target[5:0] = 6'h02;
    run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0018, 32'h0018);
    target[5:0] = 6'h00;
    oper <= 1'b0;
    run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0008, 32'h0008);
    chk(32'(o_ready), 32'h0);
    oper <= 1'b1;
    timing_on = 1'b1;
    run_op(mk(OP_READ, MODE_TRO), 1'b1, 32'h0004, 32'h1f87);
    timing_on = 1'b0;
    chk(32'(o_acc_sel), 32'h1 << m);
    chk(32'(o_ready), 32'h1);
    run_op(mk(OP_WCHK, MODE_TRO), 1'b0, 32'h0000, 32'h0200);
    bad <= 1'b1;
    run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0100, 32'h0100);
    // Single record: spoiled home skipped, zone-only track difference still matches
    run_op(mk(OP_READ, MODE_SRO), 1'b0, 32'h0000, 32'h1f00);
    spoil <= 48'h8000_0000_0000;
    run_op(mk(OP_READ, MODE_SRO), 1'b0, 32'h0100, 32'h0100);
    bad   <= 1'b0;
    spoil <= '0;
    // Actuator moves during transfer: select holds, address stays frozen
    fork
      run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0000, 32'h1f87);
      begin
        repeat (30) @(posedge i_clk);
        motion <= 1'b1;
        bus(1'b0, REG_ADDR0, {8'h0, ~target[23:0]});
        notes.push_back({32'h00ff_ffff, 8'h0, target[23:0]});
        bus(1'b1, REG_ADDR0, 32'h0);
        repeat (40) @(posedge i_clk);
        motion <= 1'b0;
      end
    join
    gok <= 1'b0;
    run_op(mk(OP_WCHK, MODE_TWA), 1'b0, 32'h0840, 32'h0840);
    gok <= 1'b1;
    wdf <= 1'b1;
    run_op(mk(OP_READ, MODE_TRO), 1'b0, 32'h0440, 32'h0440);
    wdf <= 1'b0;
    run_op(mk(OP_FORMAT, MODE_TRO), 1'b0, 32'h0080, 32'h0080);
    {fil, eight, timing_on} <= 3'b111;
    run_op(mk(OP_FORMAT, MODE_TRO) | 7'h40, 1'b0, 32'h0000, 32'h0080);
    {fil, eight, timing_on} <= 3'b000;
    frdy <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(32'(o_ready), 32'h0);
    frdy <= 1'b1;
    notes.push_back({32'hffff_ffff, 32'h0});
    bus(1'b1, 5'h18, 32'h0);
    // Let the read monitor judge the last note before the verdict
    @(posedge i_clk);
    if (notes.size() != 0) errors++;
    close_out();
  end
endmodule
